// [logic/mrs_cfg.svh]
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH
// apb register offsets
`define MRS_OFF_CTRL 12'h000
`define MRS_OFF_STAT 12'h004
`define MRS_OFF_MASK 12'h008
`define MRS_OFF_FLAG 12'h00C
`define MRS_OFF_CAUSE 12'h010
// ctrl field positions
`define MRS_CTRL_LVR_EN 0
`define MRS_CTRL_THR_LO 1
`define MRS_CTRL_PIN_EN 3
`define MRS_CTRL_CLK_LO 4
// reset values
`define MRS_CTRL_RST 32'h0000_0009
`define MRS_MASK_RST 4'h0
// times
`define MRS_CLK_MHZ 250
`define MRS_QUAL_US 100
`define MRS_RELEASE_MS 100
`define MRS_QUAL_CYC (`MRS_QUAL_US * `MRS_CLK_MHZ)
`define MRS_RELEASE_CYC (`MRS_RELEASE_MS * 1000 * `MRS_CLK_MHZ)
`define MRS_WAKE_RC 16
`define MRS_WAKE_XT 1024
`define MRS_WAKE_SLOW_INTERNAL_RC_CLOCK 2
`define MRS_SP_TOP 4'hF
`endif

// [logic/mrs_pkg.sv]
`default_nettype none
package mrs_pkg;
   typedef enum logic [2:0] {
      MRS_CLK_ERC, MRS_CLK_FAST_INTERNAL_RC_CLOCK, MRS_CLK_HXT, MRS_CLK_LXT, MRS_CLK_SLOW_INTERNAL_RC_CLOCK
   } mrs_clk_t;
   typedef enum logic [2:0] {
      MRS_SRC_NONE, MRS_SRC_POR, MRS_SRC_PIN, MRS_SRC_LVR,
      MRS_SRC_WDT_RUN, MRS_SRC_WDT_IDLE
   } mrs_src_t;
   typedef enum logic [1:0] {
      MRS_ST_RUN, MRS_ST_HOLD, MRS_ST_WAKE
   } mrs_state_t;
endpackage
`default_nettype wire

// [logic/mrs_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module mrs_sync #(
   parameter int W = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta <= '0;
         q <= '0;
      end
      else
      begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // mrs_sync
`default_nettype wire

// [logic/mrs_qual.sv]
`timescale 1ns/1ps
`default_nettype none
module mrs_qual #(
   parameter int CYC = 25000
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic en,
   input wire logic low,
   output logic trip
);
   logic [31:0] cnt;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt <= 32'h0;
         trip <= 1'b0;
      end
      else if (!en || !low)
      begin
         cnt <= 32'h0; // RULE_19
         trip <= 1'b0; // RULE_02
      end
      else if (cnt >= CYC[31:0])
         trip <= 1'b1; // RULE_01
      else
         cnt <= cnt + 32'h1;
   end
   AST_QUAL_SHORT: assert property (@(posedge pclk) disable iff (!presetn)
      !low |=> !trip) else $error("trip without low"); // RULE_02
endmodule // mrs_qual
`default_nettype wire

// [logic/mrs_top.sv]
//Function
//(RULE_01) qualified low supply in band resets
//(RULE_02) short low supply ignored, no reset
//(RULE_03) low reset enable and threshold configurable
//(RULE_04) hold core for release delay
//(RULE_05) run watchdog reset like pin, sets flag
//(RULE_06) idle watchdog clears pc, sp only
//(RULE_07) wake delay depends on clock type
//(RULE_08) power on clears both flags
//(RULE_09) pin or low reset keeps flags
//(RULE_10) run watchdog sets expired flag only
//(RULE_11) idle watchdog sets both flags
//(RULE_12) power on disables interrupts, timers
//(RULE_13) power on clears and runs watchdog
//(RULE_14) power on pins input, analog assigned
//(RULE_15) power on pc zero, sp top
//(RULE_16) per category register reset
//(RULE_17) pin reset when pin function enabled
//(RULE_18) sync sources, power on has priority
//(RULE_19) qualify timer restarts on deassert
`include "mrs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mrs_top #(
   parameter int QUAL_CYC = `MRS_QUAL_CYC,
   parameter int RELEASE_CYC = `MRS_RELEASE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic supply_low_n,
   input wire logic supply_above_floor,
   input wire logic external_reset_pin_n,
   input wire logic watchdog_timeout,
   input wire logic cpu_idle,
   output logic core_reset,
   output logic periph_reset,
   output logic pc_sp_clear,
   output logic [3:0] stack_ptr_init,
   output logic [7:0] program_counter_low,
   output logic watchdog_clear,
   output logic watchdog_expired_flag,
   output logic powerdown_flag,
   output logic irq_disable_all,
   output logic timers_off,
   output logic io_all_input,
   output logic analog_channel_pins_adc,
   output logic [1:0] low_supply_threshold,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////
   logic [31:0] ctrl;
   logic [3:0] stat;
   logic [3:0] mask;
   logic [2:0] sync_q;
   logic low_q;
   logic pin_q;
   logic wdt_q;
   logic lvr_trip;
   logic lvr_d;
   logic pin_d;
   logic wdt_d;
   logic por_done;
   logic [31:0] cnt;
   logic [3:0] ev;
   mrs_pkg::mrs_state_t state;
   mrs_pkg::mrs_src_t cause;
   mrs_pkg::mrs_src_t next_src;
   logic hold_next;
   logic acc;
   logic wr;
   logic dec_ok;
   assign hold_next = (state == mrs_pkg::MRS_ST_HOLD)
      || ((next_src != mrs_pkg::MRS_SRC_NONE)
      && (next_src != mrs_pkg::MRS_SRC_WDT_IDLE));
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   function automatic logic [31:0] wake_cyc(input logic [2:0] c);
      case (c)
         3'h2, 3'h3: wake_cyc = `MRS_WAKE_XT;
         3'h4: wake_cyc = `MRS_WAKE_SLOW_INTERNAL_RC_CLOCK;
         default: wake_cyc = `MRS_WAKE_RC;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////
   mrs_sync #(.W(3)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({~supply_low_n & supply_above_floor, ~external_reset_pin_n,
          watchdog_timeout}),
      .q(sync_q)
   ); // RULE_18
   assign low_q = sync_q[2];
   assign pin_q = sync_q[1] & ctrl[`MRS_CTRL_PIN_EN]; // RULE_17
   assign wdt_q = sync_q[0];
   mrs_qual #(.CYC(QUAL_CYC)) u_qual (
      .pclk(pclk),
      .presetn(presetn),
      .en(ctrl[`MRS_CTRL_LVR_EN]),
      .low(low_q),
      .trip(lvr_trip)
   ); // RULE_03
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lvr_d <= 1'b0;
         pin_d <= 1'b0;
         wdt_d <= 1'b0;
      end
      else
      begin
         lvr_d <= lvr_trip;
         pin_d <= pin_q;
         wdt_d <= wdt_q;
      end
   end
   always_comb
   begin
      next_src = mrs_pkg::MRS_SRC_NONE;
      if (!por_done)
         next_src = mrs_pkg::MRS_SRC_POR; // RULE_18
      else if (lvr_trip && !lvr_d)
         next_src = mrs_pkg::MRS_SRC_LVR;
      else if (pin_q && !pin_d)
         next_src = mrs_pkg::MRS_SRC_PIN;
      else if (wdt_q && !wdt_d)
         next_src = cpu_idle ? mrs_pkg::MRS_SRC_WDT_IDLE
                             : mrs_pkg::MRS_SRC_WDT_RUN; // RULE_05
   end
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= mrs_pkg::MRS_ST_RUN;
         cause <= mrs_pkg::MRS_SRC_NONE;
         cnt <= 32'h0;
         por_done <= 1'b0;
      end
      else if (next_src != mrs_pkg::MRS_SRC_NONE)
      begin
         por_done <= 1'b1;
         cause <= next_src; // RULE_16
         cnt <= 32'h0;
         if (next_src == mrs_pkg::MRS_SRC_WDT_IDLE)
            state <= mrs_pkg::MRS_ST_WAKE; // RULE_06
         else
            state <= mrs_pkg::MRS_ST_HOLD; // RULE_04
      end
      else
      begin
         case (state)
            mrs_pkg::MRS_ST_HOLD:
            begin
               if (pin_q || lvr_trip)
                  cnt <= 32'h0;
               else if (cnt >= RELEASE_CYC[31:0] - 32'h1)
                  state <= mrs_pkg::MRS_ST_RUN; // RULE_04
               else
                  cnt <= cnt + 32'h1;
            end
            mrs_pkg::MRS_ST_WAKE:
            begin
               if (cnt >= wake_cyc(ctrl[`MRS_CTRL_CLK_LO +: 3]) - 32'h1)
                  state <= mrs_pkg::MRS_ST_RUN; // RULE_07
               else
                  cnt <= cnt + 32'h1;
            end
            default: cnt <= 32'h0;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         core_reset <= 1'b1;
         periph_reset <= 1'b1;
         pc_sp_clear <= 1'b0;
         watchdog_clear <= 1'b1;
         irq_disable_all <= 1'b1;
         timers_off <= 1'b1;
         io_all_input <= 1'b1;
         analog_channel_pins_adc <= 1'b1;
         stack_ptr_init <= `MRS_SP_TOP;
         program_counter_low <= 8'h00;
      end
      else
      begin
         core_reset <= hold_next; // RULE_04
         periph_reset <= hold_next; // RULE_16
         pc_sp_clear <= (state == mrs_pkg::MRS_ST_WAKE); // RULE_06
         watchdog_clear <= (next_src == mrs_pkg::MRS_SRC_POR); // RULE_13
         irq_disable_all <= hold_next; // RULE_12
         timers_off <= hold_next; // RULE_12
         io_all_input <= hold_next; // RULE_14
         analog_channel_pins_adc <= hold_next; // RULE_14
         stack_ptr_init <= (state == mrs_pkg::MRS_ST_WAKE) ? 4'h0
                           : `MRS_SP_TOP; // RULE_15
         program_counter_low <= 8'h00; // RULE_16
      end
   end
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         watchdog_expired_flag <= 1'b0; // RULE_08
         powerdown_flag <= 1'b0; // RULE_08
      end
      else if (next_src == mrs_pkg::MRS_SRC_POR)
      begin
         watchdog_expired_flag <= 1'b0; // RULE_08
         powerdown_flag <= 1'b0;
      end
      else if (next_src == mrs_pkg::MRS_SRC_WDT_RUN)
         watchdog_expired_flag <= 1'b1; // RULE_10
      else if (next_src == mrs_pkg::MRS_SRC_WDT_IDLE)
      begin
         watchdog_expired_flag <= 1'b1; // RULE_11
         powerdown_flag <= 1'b1; // RULE_11
      end
      else if (wr && paddr == `MRS_OFF_FLAG)
      begin
         watchdog_expired_flag <= pwdata[0];
         powerdown_flag <= pwdata[1];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   assign ev[0] = (next_src == mrs_pkg::MRS_SRC_LVR);
   assign ev[1] = (next_src == mrs_pkg::MRS_SRC_PIN);
   assign ev[2] = (next_src == mrs_pkg::MRS_SRC_WDT_RUN);
   assign ev[3] = (next_src == mrs_pkg::MRS_SRC_WDT_IDLE);
   always_comb
   begin
      case (paddr)
         `MRS_OFF_CTRL, `MRS_OFF_STAT, `MRS_OFF_MASK,
         `MRS_OFF_FLAG, `MRS_OFF_CAUSE: dec_ok = 1'b1;
         default: dec_ok = 1'b0;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= `MRS_CTRL_RST;
         mask <= `MRS_MASK_RST;
         stat <= 4'h0;
      end
      else
      begin
         if (wr && paddr == `MRS_OFF_CTRL)
            ctrl <= {25'h0, pwdata[6:0]}; // RULE_03
         if (wr && paddr == `MRS_OFF_MASK)
            mask <= pwdata[3:0];
         if (wr && paddr == `MRS_OFF_STAT)
            stat <= (stat & ~pwdata[3:0]) | ev;
         else
            stat <= stat | ev;
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq <= 1'b0;
         low_supply_threshold <= 2'h0;
      end
      else
      begin
         irq <= |(stat & mask);
         low_supply_threshold <= ctrl[`MRS_CTRL_THR_LO +: 2]; // RULE_03
         pready <= psel && !penable;
         pslverr <= psel && !penable && !dec_ok;
         prdata <= 32'h0;
         if (psel && !penable && !pwrite)
         begin
            case (paddr)
               `MRS_OFF_CTRL: prdata <= ctrl;
               `MRS_OFF_STAT: prdata <= {28'h0, stat};
               `MRS_OFF_MASK: prdata <= {28'h0, mask};
               `MRS_OFF_FLAG: prdata <= {30'h0, powerdown_flag,
                                         watchdog_expired_flag};
               `MRS_OFF_CAUSE: prdata <= {29'h0, cause};
               default: prdata <= 32'h0;
            endcase
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   sequence s_wdt_run;
      next_src == mrs_pkg::MRS_SRC_WDT_RUN;
   endsequence
   sequence s_wdt_idle;
      next_src == mrs_pkg::MRS_SRC_WDT_IDLE;
   endsequence
   AST_RUN_WDT_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
      s_wdt_run |=> watchdog_expired_flag && $stable(powerdown_flag))
      else $error("run watchdog flags wrong"); // RULE_10
   AST_IDLE_WDT_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
      s_wdt_idle |=> watchdog_expired_flag && powerdown_flag)
      else $error("idle watchdog flags wrong"); // RULE_11
   AST_PIN_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
      (next_src == mrs_pkg::MRS_SRC_PIN) |=> $stable(powerdown_flag)
      && $stable(watchdog_expired_flag))
      else $error("pin changed flag"); // RULE_09
   AST_IDLE_NO_CORE: assert property (@(posedge pclk) disable iff (!presetn)
      s_wdt_idle |=> !core_reset)
      else $error("idle watchdog reset the core"); // RULE_06
   AST_POR_WDT_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      (next_src == mrs_pkg::MRS_SRC_POR) |=> watchdog_clear)
      else $error("watchdog not cleared at power on"); // RULE_13
   AST_IDLE_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
      s_wdt_idle |=> state == mrs_pkg::MRS_ST_WAKE ##1 pc_sp_clear)
      else $error("no wake after idle watchdog"); // RULE_06
   AST_HOLD_RESET: assert property (@(posedge pclk) disable iff (!presetn)
      state == mrs_pkg::MRS_ST_HOLD |=> core_reset)
      else $error("core not held"); // RULE_04
   AST_POR_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
      !por_done |-> next_src == mrs_pkg::MRS_SRC_POR)
      else $error("power on not first"); // RULE_18
   AST_LVR_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
      (por_done && $rose(lvr_trip)) |=> cause == mrs_pkg::MRS_SRC_LVR)
      else $error("low supply not reset"); // RULE_01
   AST_PIN_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl[`MRS_CTRL_PIN_EN] |-> next_src != mrs_pkg::MRS_SRC_PIN)
      else $error("pin reset while disabled"); // RULE_17
endmodule // mrs_top
`default_nettype wire

// [tb/mrs_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mrs_core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic core_reset,
   input wire logic pc_sp_clear,
   input wire logic [3:0] stack_ptr_init,
   input wire logic [7:0] program_counter_low,
   output logic [7:0] pc,
   output logic [3:0] sp
);
   // core loads its start state on core_reset or pc_sp_clear, clears pc and sp to zero on presetn, runs otherwise
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pc <= 8'h00;
         sp <= 4'h0;
      end
      else if (core_reset || pc_sp_clear)
      begin
         pc <= program_counter_low;
         sp <= stack_ptr_init;
      end
      else
         pc <= pc + 8'h01;
   end
endmodule // mrs_core_model
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, rv;
logic supply_low_n, supply_above_floor, external_reset_pin_n;
logic watchdog_timeout, cpu_idle, core_reset, periph_reset, pc_sp_clear;
logic [3:0] stack_ptr_init, sp;
logic [7:0] program_counter_low, pc;
logic watchdog_clear, watchdog_expired_flag, powerdown_flag;
logic irq_disable_all, timers_off, io_all_input, analog_channel_pins_adc, irq;
logic [1:0] low_supply_threshold;
int error_cnt, check_count;
int lo[5] = '{15, 15, 1024, 1024, 1};
int hi[5] = '{16, 16, 1024, 1024, 2};
mrs_top #(.QUAL_CYC(8), .RELEASE_CYC(16)) mrs_top_inst (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .supply_low_n, .supply_above_floor, .external_reset_pin_n,
   .watchdog_timeout, .cpu_idle, .core_reset, .periph_reset, .pc_sp_clear,
   .stack_ptr_init, .program_counter_low, .watchdog_clear,
   .watchdog_expired_flag, .powerdown_flag, .irq_disable_all, .timers_off,
   .io_all_input, .analog_channel_pins_adc, .low_supply_threshold, .irq);
mrs_core_model mrs_core_model_inst (.pclk, .presetn, .core_reset,
   .pc_sp_clear, .stack_ptr_init, .program_counter_low, .pc, .sp);
initial
begin
   pclk = 0;
   forever #2 pclk = ~pclk;
end
////////////////////////////////////////////////////////////////////////////
task finish_test;
   $display("errors %0d checks %0d", error_cnt, check_count);
   if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
   else
      $display("verification failed");
   $finish;
endtask
task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
   check_count++;
   if (s !== e)
   begin
      error_cnt++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm, e, s);
   end
endtask
task tick(input int n);
   repeat (n) @(posedge pclk);
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
   int n;
   @(posedge pclk);
   psel <= 1;
   penable <= 0;
   pwrite <= w;
   paddr <= a;
   pwdata <= d;
   @(posedge pclk);
   penable <= 1;
   n = 0;
   do
   begin
      @(posedge pclk);
      n++;
   end while (pready !== 1'b1 && n < 50);
   rv = prdata;
   chk("pslverr", pslverr, a > 12'h010);
   psel <= 0;
   penable <= 0;
   if (n == 50)
   begin
      error_cnt++;
      finish_test();
   end
endtask
task rd(input logic [11:0] a, input logic [31:0] e);
   apb(0, a, 32'h0);
   chk("prdata", rv, e);
endtask
task wait_for(input logic v, input int which);
   int n;
   n = 0;
   while ((which ? pc_sp_clear : core_reset) !== v && n < 300)
   begin
      @(posedge pclk);
      n++;
   end
   if (n == 300)
   begin
      error_cnt++;
      finish_test();
   end
endtask
task pulse_wdt;
   @(posedge pclk);
   watchdog_timeout <= 1;
   tick(3);
   watchdog_timeout <= 0;
endtask
////////////////////////////////////////////////////////////////////////////
task t_por;
   int n;
   chk("wdt_clear", watchdog_clear, 1);
   @(posedge pclk);
   presetn <= 1;
   tick(2);
   chk("por_outs", {periph_reset, irq_disable_all, timers_off, io_all_input,
      analog_channel_pins_adc, stack_ptr_init, program_counter_low,
      powerdown_flag, watchdog_expired_flag}, {5'h1F, 4'hF, 10'h0});
   n = 0;
   while (core_reset === 1'b1 && n < 300)
   begin
      @(posedge pclk);
      n++;
   end
   chk("hold", n >= 15 && n < 300, 1);
   chk("wdt_run", watchdog_clear, 0);
   chk("sp", sp, 4'hF);
   rd(`MRS_OFF_CTRL, `MRS_CTRL_RST);
   rd(`MRS_OFF_MASK, 32'h0);
   rd(12'h020, 32'h0);
endtask
task t_idle;
   int n;
   for (int k = 0; k < 5; k++)
   begin
      apb(1, `MRS_OFF_CTRL, 32'(k << 4) | 32'h9);
      cpu_idle <= 1;
      pulse_wdt();
      wait_for(1, 1);
      chk("idle_sp", {core_reset, stack_ptr_init}, 5'h0);
      n = 0;
      while (pc_sp_clear === 1'b1 && n < 1100)
      begin
         @(posedge pclk);
         n++;
      end
      chk("wake_len", n >= lo[k] && n <= hi[k] + 1, 1);
      chk("idle_flags", {powerdown_flag, watchdog_expired_flag}, 3);
      chk("model_sp", sp, 4'h0);
      cpu_idle <= 0;
   end
   rd(`MRS_OFF_STAT, 32'h8);
   apb(1, `MRS_OFF_STAT, 32'hF);
endtask
task t_pin;
   external_reset_pin_n <= 0;
   wait_for(1, 0);
   tick(5);
   external_reset_pin_n <= 1;
   wait_for(0, 0);
   chk("pin_flags", {powerdown_flag, watchdog_expired_flag}, 3);
   chk("model_sp", sp, 4'hF);
   apb(1, `MRS_OFF_CTRL, 32'h1);
   external_reset_pin_n <= 0;
   tick(20);
   chk("pin_off", core_reset, 0);
   external_reset_pin_n <= 1;
   apb(1, `MRS_OFF_CTRL, 32'h9);
endtask
task t_lvr;
   supply_low_n <= 0;
   tick(4);
   supply_low_n <= 1;
   tick(1);
   supply_low_n <= 0;
   tick(6);
   supply_low_n <= 1;
   tick(20);
   chk("short_low", core_reset, 0);
   supply_above_floor <= 0;
   supply_low_n <= 0;
   tick(30);
   chk("below_floor", core_reset, 0);
   apb(1, `MRS_OFF_CTRL, 32'h8);
   supply_above_floor <= 1;
   tick(30);
   chk("lvr_off", core_reset, 0);
   supply_low_n <= 1;
   apb(1, `MRS_OFF_CTRL, 32'hD);
   tick(2);
   chk("thr", low_supply_threshold, 2);
   supply_low_n <= 0;
   wait_for(1, 0);
   supply_low_n <= 1;
   wait_for(0, 0);
   chk("lvr_flags", {powerdown_flag, watchdog_expired_flag}, 3);
   rd(`MRS_OFF_STAT, 32'h3);
   apb(1, `MRS_OFF_STAT, 32'hF);
endtask
task t_wdt_run;
   apb(1, `MRS_OFF_FLAG, 32'h0);
   apb(1, `MRS_OFF_MASK, 32'h4);
   pulse_wdt();
   wait_for(1, 0);
   tick(3);
   chk("irq_on", irq, 1);
   wait_for(0, 0);
   chk("run_flags", {powerdown_flag, watchdog_expired_flag}, 1);
   rd(`MRS_OFF_STAT, 32'h4);
   apb(1, `MRS_OFF_MASK, 32'h0);
   tick(2);
   chk("irq_masked", irq, 0);
   apb(1, `MRS_OFF_MASK, 32'h4);
   apb(1, `MRS_OFF_STAT, 32'h4);
   tick(2);
   chk("irq_clr", irq, 0);
   rd(`MRS_OFF_STAT, 32'h0);
   @(posedge pclk);
   presetn <= 0;
   tick(2);
   chk("por_flags", {powerdown_flag, watchdog_expired_flag}, 0);
   presetn <= 1;
   tick(2);
   chk("por_again", {core_reset, periph_reset}, 3);
endtask
////////////////////////////////////////////////////////////////////////////
initial
begin
   error_cnt = 0;
   check_count = 0;
   presetn = 0;
   {psel, penable, pwrite, paddr, pwdata} = '0;
   {supply_low_n, supply_above_floor, external_reset_pin_n} = 3'b111;
   {watchdog_timeout, cpu_idle} = 2'b00;
   tick(6);
   t_por();
   t_idle();
   t_pin();
   t_lvr();
   t_wdt_run();
   finish_test();
end
endmodule // testbench
`default_nettype wire
